// ==== hw/fsi_top.sv ====
// front-panel switch interlock with APB settings
// Functional notes
// - switch drives one selectable input function, default position preset code 9
// - sense setting: 0 passes switch state, 1 inverts it, default 0
// - while locked, switch must be held 1..50 steps (default 10) to accept
// - interlocked by default; hold time 0 disables the interlock
// - released state lasts one step more than its 0..50 setting, default 30
// - indicator LED lit 0..50 steps (default 10) when assigned signal input
// - preset function: accepted press loads present position as home
// - start function: accepted press begins operation
`timescale 1ns/1ps
`default_nettype none
module fsi_top #(
  parameter int STEP_CYCLES = fsi_pkg::STEP_CYCLES
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SWITCH_PRESSED,
  output logic EXTENDED_SWITCH_INPUT,
  output logic [7:0] FUNC_CODE,
  output logic POSITION_PRESET,
  output logic OPERATION_START,
  output logic SWITCH_LED
);
  // ---------------------------------------------------------------
  // settings registers
  // ---------------------------------------------------------------
  logic [7:0] func_sel;
  logic invert;
  logic [5:0] hold_time;
  logic [5:0] rel_dur;
  logic [5:0] led_time;
  logic wr_en;
  logic valid_addr;
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign PREADY = 1'b1;
  function automatic logic fsi_mapped(input logic [11:0] a);
    fsi_mapped = (a == fsi_pkg::OFF_FUNC_SEL) || (a == fsi_pkg::OFF_INVERT) ||
      (a == fsi_pkg::OFF_HOLD_TIME) || (a == fsi_pkg::OFF_REL_DUR) ||
      (a == fsi_pkg::OFF_LED_TIME) || (a == fsi_pkg::OFF_STATUS);
  endfunction : fsi_mapped
  function automatic logic [5:0] fsi_clip(input logic [31:0] v);
    fsi_clip = (v > 32'(fsi_pkg::MAX_TIME)) ? fsi_pkg::MAX_TIME : v[5:0];
  endfunction : fsi_clip
  assign valid_addr = fsi_mapped(PADDR);
  // unmapped access answers with an error, no state change
  assign PSLVERR = PSEL && PENABLE && !valid_addr;
  // writes land at the access edge; times clip to 50 steps
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      func_sel <= fsi_pkg::FUNC_PRESET;
      invert <= fsi_pkg::RST_INVERT;
      hold_time <= fsi_pkg::RST_HOLD_TIME;
      rel_dur <= fsi_pkg::RST_REL_DUR;
      led_time <= fsi_pkg::RST_LED_TIME;
    end else if (wr_en) begin
      unique case (PADDR)
        fsi_pkg::OFF_FUNC_SEL: func_sel <= PWDATA[7:0];
        fsi_pkg::OFF_INVERT: invert <= PWDATA[0];
        fsi_pkg::OFF_HOLD_TIME: hold_time <= fsi_clip(PWDATA);
        fsi_pkg::OFF_REL_DUR: rel_dur <= fsi_clip(PWDATA);
        fsi_pkg::OFF_LED_TIME: led_time <= fsi_clip(PWDATA);
        default: ;
      endcase
    end
  end
  // ---------------------------------------------------------------
  // switch input: synchroniser and sense
  // ---------------------------------------------------------------
  logic sw_meta;
  logic sw_sync;
  logic sw_on;
  // metastability guard; only sw_sync reads sw_meta
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sw_meta <= 1'b0;
      sw_sync <= 1'b0;
    end else begin
      sw_meta <= SWITCH_PRESSED;
      sw_sync <= sw_meta;
    end
  end
  assign sw_on = sw_sync ^ invert;
  // ---------------------------------------------------------------
  // interlock state machine on the step tick
  // ---------------------------------------------------------------
  logic tick;
  fsi_tick #(.STEP_CYCLES(STEP_CYCLES)) u_tick (
    .clk(CLK),
    .reset_n(RESET_N),
    .tick(tick)
  );
  fsi_pkg::fsi_state_e state;
  logic [5:0] step_cnt;
  logic bypass;
  logic enabled;
  assign bypass = (hold_time == 6'h00);
  assign enabled = bypass || (state == fsi_pkg::FSI_RELEASED);
  // a release-window of zero relocks on the next step
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state <= fsi_pkg::FSI_LOCKED;
      step_cnt <= 6'h00;
    end else if (bypass) begin
      state <= fsi_pkg::FSI_LOCKED;
      step_cnt <= 6'h00;
    end else begin
      unique case (state)
        fsi_pkg::FSI_LOCKED: begin
          step_cnt <= 6'h00;
          if (sw_on) begin
            state <= fsi_pkg::FSI_HOLDING;
          end
        end
        fsi_pkg::FSI_HOLDING: begin
          if (!sw_on) begin
            state <= fsi_pkg::FSI_LOCKED;
            step_cnt <= 6'h00;
          end else if (tick) begin
            if (step_cnt + 6'h01 >= hold_time) begin
              state <= fsi_pkg::FSI_RELEASED;
              step_cnt <= 6'h00;
            end else begin
              step_cnt <= step_cnt + 6'h01;
            end
          end
        end
        fsi_pkg::FSI_RELEASED: begin
          if (tick) begin
            if (step_cnt >= rel_dur) begin
              state <= fsi_pkg::FSI_LOCKED;
              step_cnt <= 6'h00;
            end else begin
              step_cnt <= step_cnt + 6'h01;
            end
          end
        end
        default: begin
          state <= fsi_pkg::FSI_LOCKED;
          step_cnt <= 6'h00;
        end
      endcase
    end
  end
  // ---------------------------------------------------------------
  // function outputs and LED
  // ---------------------------------------------------------------
  logic sig_in;
  logic sig_prev;
  logic [5:0] led_cnt;
  assign sig_in = sw_on && enabled;
  // press edge while enabled fires the chosen function once
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sig_prev <= 1'b0;
      EXTENDED_SWITCH_INPUT <= 1'b0;
      FUNC_CODE <= fsi_pkg::FUNC_PRESET;
      POSITION_PRESET <= 1'b0;
      OPERATION_START <= 1'b0;
    end else begin
      sig_prev <= sig_in;
      EXTENDED_SWITCH_INPUT <= sig_in;
      FUNC_CODE <= func_sel;
      POSITION_PRESET <= sig_in && !sig_prev && (func_sel == fsi_pkg::FUNC_PRESET);
      OPERATION_START <= sig_in && !sig_prev && (func_sel == fsi_pkg::FUNC_START);
    end
  end
  // LED timer restarts on every input of the assigned signal
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      led_cnt <= 6'h00;
      SWITCH_LED <= 1'b0;
    end else if (sig_in && !sig_prev) begin
      led_cnt <= led_time;
      SWITCH_LED <= (led_time != 6'h00);
    end else if (tick && led_cnt != 6'h00) begin
      led_cnt <= led_cnt - 6'h01;
      SWITCH_LED <= (led_cnt != 6'h01);
    end
  end
  // read mux registered from the setup phase
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PRDATA <= 32'h00000000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      unique case (PADDR)
        fsi_pkg::OFF_FUNC_SEL: PRDATA <= {24'h000000, func_sel};
        fsi_pkg::OFF_INVERT: PRDATA <= {31'h0, invert};
        fsi_pkg::OFF_HOLD_TIME: PRDATA <= {26'h0, hold_time};
        fsi_pkg::OFF_REL_DUR: PRDATA <= {26'h0, rel_dur};
        fsi_pkg::OFF_LED_TIME: PRDATA <= {26'h0, led_time};
        fsi_pkg::OFF_STATUS: PRDATA <= {28'h0000000, sw_on, SWITCH_LED, enabled, !enabled};
        default: PRDATA <= 32'h00000000;
      endcase
    end
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_relock;
    state == fsi_pkg::FSI_RELEASED ##1 state == fsi_pkg::FSI_LOCKED;
  endsequence
  a_hold_needed: assert property (@(posedge CLK) disable iff (!RESET_N)
    $rose(state == fsi_pkg::FSI_RELEASED) |-> $past(state) == fsi_pkg::FSI_HOLDING && $past(sw_on))
    else $error("release without hold");
  a_locked_ignores: assert property (@(posedge CLK) disable iff (!RESET_N)
    (!enabled) |=> !EXTENDED_SWITCH_INPUT) else $error("input passed while locked");
  a_bypass_direct: assert property (@(posedge CLK) disable iff (!RESET_N)
    (bypass && sw_on) |=> EXTENDED_SWITCH_INPUT) else $error("bypass did not pass press");
  a_sense_invert: assert property (@(posedge CLK) disable iff (!RESET_N)
    bypass |=> EXTENDED_SWITCH_INPUT == ($past(sw_sync) != $past(invert))) else $error("sense wrong");
  a_relock_fresh: assert property (@(posedge CLK) disable iff (!RESET_N)
    s_relock |-> step_cnt == 6'h00) else $error("relock kept count");
  a_window_len: assert property (@(posedge CLK) disable iff (!RESET_N)
    state == fsi_pkg::FSI_RELEASED |-> step_cnt <= rel_dur) else $error("window overrun");
  a_preset_fire: assert property (@(posedge CLK) disable iff (!RESET_N)
    (sig_in && !sig_prev && func_sel == fsi_pkg::FUNC_PRESET) |=> POSITION_PRESET)
    else $error("preset missed");
  a_start_fire: assert property (@(posedge CLK) disable iff (!RESET_N)
    (sig_in && !sig_prev && func_sel == fsi_pkg::FUNC_START) |=> OPERATION_START)
    else $error("start missed");
  a_led_on: assert property (@(posedge CLK) disable iff (!RESET_N)
    (sig_in && !sig_prev && led_time != 6'h00) |=> SWITCH_LED) else $error("led not lit");
  a_func_out: assert property (@(posedge CLK) disable iff (!RESET_N)
    ##1 FUNC_CODE == $past(func_sel)) else $error("func code stale");
endmodule : fsi_top
`default_nettype wire

// ==== hw/fsi_pkg.sv ====
// constants shared by the front switch interlock block
package fsi_pkg;
  // ---------------------------------------------------------------
  // register map (APB byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] OFF_FUNC_SEL = 12'h000;
  localparam logic [11:0] OFF_INVERT = 12'h004;
  localparam logic [11:0] OFF_HOLD_TIME = 12'h008;
  localparam logic [11:0] OFF_REL_DUR = 12'h00c;
  localparam logic [11:0] OFF_LED_TIME = 12'h010;
  localparam logic [11:0] OFF_STATUS = 12'h014;
  // ---------------------------------------------------------------
  // reset values and field layout
  // ---------------------------------------------------------------
  localparam logic [7:0] FUNC_PRESET = 8'h09;
  localparam logic [7:0] FUNC_START = 8'h01;
  localparam logic RST_INVERT = 1'b0;
  localparam logic [5:0] RST_HOLD_TIME = 6'h0a;
  localparam logic [5:0] RST_REL_DUR = 6'h1e;
  localparam logic [5:0] RST_LED_TIME = 6'h0a;
  localparam logic [5:0] MAX_TIME = 6'h32;
  localparam int STAT_LOCKED = 0;
  localparam int STAT_RELEASED = 1;
  localparam int STAT_LED = 2;
  localparam int STAT_SWITCH = 3;
  // ---------------------------------------------------------------
  // timing: one step is 0.1 s
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 10000000;
  localparam int STEP_MS = 100;
  localparam int STEP_CYCLES = CLK_HZ / 1000 * STEP_MS;
  // interlock states
  typedef enum logic [1:0] {
    FSI_LOCKED = 2'b00,
    FSI_HOLDING = 2'b01,
    FSI_RELEASED = 2'b10
  } fsi_state_e;
endpackage : fsi_pkg

// ==== hw/fsi_tick.sv ====
// divider that makes the 0.1 s step enable
`timescale 1ns/1ps
`default_nettype none
module fsi_tick #(
  parameter int STEP_CYCLES = fsi_pkg::STEP_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  output logic tick
);
  logic [23:0] count;
  // free running count; one pulse per step
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= 24'h000000;
      tick <= 1'b0;
    end else if (count == 24'(STEP_CYCLES - 1)) begin
      count <= 24'h000000;
      tick <= 1'b1;
    end else begin
      count <= count + 24'h000001;
      tick <= 1'b0;
    end
  end
endmodule : fsi_tick
`default_nettype wire

// ==== tb/fsi_push_switch.sv ====
// model of the hand-pressed front panel switch
`timescale 1ns/1ps
`default_nettype none
module fsi_push_switch (
  input wire logic hand_down,
  output logic contact
);
  // ----------------------------------------
  // contact follower
  // ----------------------------------------
  // contact follows the hand 37 ns later, unrelated to the clock; unknown until the first 37 ns have passed
  assign #37 contact = hand_down;
endmodule : fsi_push_switch
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the front switch interlock
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, hand = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err_seen, sw, extended_switch_input, preset, start, led;
  logic [7:0] func_code;
  int errors = 0, total_checks = 0, preset_cnt = 0, start_cnt = 0;
  fsi_push_switch sw_model (.hand_down(hand), .contact(sw));
  fsi_top #(.STEP_CYCLES(10)) dut (.CLK(clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SWITCH_PRESSED(sw), .EXTENDED_SWITCH_INPUT(extended_switch_input), .FUNC_CODE(func_code),
    .POSITION_PRESET(preset), .OPERATION_START(start), .SWITCH_LED(led));
  // ----------------------------------------
  // clock and pulse counters
  // ----------------------------------------
  // 100 ns period
  initial begin
    forever #50 clk = ~clk;
  end
  // one-cycle pulses are counted so none is missed between checks
  always @(posedge clk) begin
    if (preset === 1'b1) preset_cnt++;
    if (start === 1'b1) start_cnt++;
  end
  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk("read data", exp, rd);
  endtask : rd_chk
  // hand held down for n clock cycles, then let go
  task automatic press(input int n);
    @(posedge clk);
    hand <= 1'b1;
    repeat (n) @(posedge clk);
    hand <= 1'b0;
  endtask : press
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  // the tests need under 1000 cycles
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    conclude();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    chk("func code", 32'h9, {24'h0, func_code});
    rd_chk(fsi_pkg::OFF_FUNC_SEL, 32'h9);
    rd_chk(fsi_pkg::OFF_INVERT, 32'h0);
    rd_chk(fsi_pkg::OFF_HOLD_TIME, 32'ha);
    rd_chk(fsi_pkg::OFF_REL_DUR, 32'h1e);
    rd_chk(fsi_pkg::OFF_LED_TIME, 32'ha);
    rd_chk(fsi_pkg::OFF_STATUS, 32'h1);
    // out of range time is clipped to 50 steps
    apb(1'b1, fsi_pkg::OFF_HOLD_TIME, 32'h3f);
    rd_chk(fsi_pkg::OFF_HOLD_TIME, 32'h32);
    apb(1'b1, fsi_pkg::OFF_HOLD_TIME, 32'h2);
    apb(1'b1, fsi_pkg::OFF_REL_DUR, 32'h5);
    apb(1'b1, fsi_pkg::OFF_LED_TIME, 32'h5);
    // a press shorter than one step stays locked out
    press(5);
    repeat (30) @(posedge clk);
    chk("preset count short", 32'h0, preset_cnt);
    // long press releases the interlock and presets home
    fork
      press(60);
      begin
        repeat (32) @(posedge clk);
        chk("assigned signal", 32'h1, {31'h0, extended_switch_input});
        chk("led", 32'h1, {31'h0, led});
      end
    join
    chk("preset count long", 32'h1, preset_cnt);
    repeat (100) @(posedge clk);
    rd_chk(fsi_pkg::OFF_STATUS, 32'h1);
    press(5);
    repeat (30) @(posedge clk);
    chk("preset count relocked", 32'h1, preset_cnt);
    // hold time zero: a short press acts at once
    apb(1'b1, fsi_pkg::OFF_HOLD_TIME, 32'h0);
    press(5);
    repeat (10) @(posedge clk);
    chk("preset count bypass", 32'h2, preset_cnt);
    // start function instead of preset
    apb(1'b1, fsi_pkg::OFF_FUNC_SEL, 32'h1);
    // the function code output trails the setting by one register stage
    repeat (2) @(posedge clk);
    chk("func code start", 32'h1, {24'h0, func_code});
    press(5);
    repeat (10) @(posedge clk);
    chk("start count", 32'h1, start_cnt);
    chk("preset count start", 32'h2, preset_cnt);
    // inverted sense: idle switch reads as active
    apb(1'b1, fsi_pkg::OFF_INVERT, 32'h1);
    repeat (10) @(posedge clk);
    chk("inverted signal", 32'h1, {31'h0, extended_switch_input});
    chk("start count invert", 32'h2, start_cnt);
    // unmapped address is refused
    rd_chk(12'h020, 32'h0);
    chk("slave error", 32'h1, {31'h0, err_seen});
    conclude();
  end
endmodule : testbench
`default_nettype wire
